// ==== rtl/ffcl_top.sv ====
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module ffcl_top import ffcl_pkg::*; #(
	parameter int ERASE_CYCLES = ERASE_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic ifetch_req,
	input wire logic [14:0] ifetch_addr,
	output logic ifetch_rvalid,
	output logic [7:0] ifetch_rdata,
	input wire logic cread_req,
	input wire logic cread_extended_data_space,
	input wire logic [15:0] cread_addr,
	output logic cread_rvalid,
	output logic [7:0] cread_rdata,
	input wire logic [7:0] port0_in,
	input wire logic [7:0] port1_in,
	output logic fl_rd_req,
	output logic fl_rd_info,
	output logic [12:0] fl_rd_word,
	input wire logic fl_rd_valid,
	input wire logic [31:0] fl_rd_data,
	output logic fl_pgm_start,
	output logic [1:0] fl_pgm_op,
	output logic [16:0] fl_pgm_addr,
	output logic [31:0] fl_pgm_wdata,
	input wire logic debug_mode,
	input wire logic dbg_cmd_valid,
	input wire logic dbg_cmd_safe,
	output logic dbg_cmd_accept
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		ffcl_state_t state;
		logic fill_c;
		logic fill_info;
		logic issued;
		logic [12:0] fill_word;
		logic [1:0] fill_lane;
		logic i_v;
		logic [12:0] i_word;
		logic [31:0] i_data;
		logic c_v;
		logic c_info;
		logic [12:0] c_word;
		logic [31:0] c_data;
		logic p_v;
		logic [12:0] p_word;
		logic [31:0] p_data;
		logic i_rvalid;
		logic [7:0] i_rdata;
		logic c_rvalid;
		logic [7:0] c_rdata;
		logic [1:0] mode;
		logic refused;
		logic [31:0] lock;
		logic [19:0] busy_cnt;
		logic [16:0] addr;
		logic [31:0] wdata;
		logic [1:0] op;
		logic pgm_start;
		logic aw_v;
		logic [7:0] aw_a;
		logic w_v;
		logic [31:0] w_d;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ffcl_regs_t;

	localparam ffcl_regs_t REGS_RESET = '{
		state: ST_IDLE, mode: CM_RESET, lock: LOCK_RESET, bresp: AXI_OKAY, rresp: AXI_OKAY, default: '0
	};

	ffcl_regs_t s_r;
	ffcl_regs_t s_nxt;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] byte_sel(input logic [31:0] w, input logic [1:0] lane);
		byte_sel = w[8 * lane +: 8];
	endfunction

	function automatic ffcl_ckind_t cdecode(input logic xd, input logic [15:0] a);
		if (!xd) begin
			cdecode = a < XBANK_BASE ? CK_FLASH : CK_NONE;
		end else if (a == PORT0_XADDR) begin
			cdecode = CK_PORT0;
		end else if (a == PORT1_XADDR) begin
			cdecode = CK_PORT1;
		end else if (a >= XBANK_BASE) begin
			cdecode = CK_FLASH;
		end else if (a >= INFO_XBASE) begin
			cdecode = CK_INFO;
		end else begin
			cdecode = CK_NONE;
		end
	endfunction

	// page lock check; the lock page itself needs debug mode
	function automatic logic page_locked(input logic [31:0] lk, input logic [4:0] pg, input logic dm);
		if (pg == TOP_PAGE) begin
			page_locked = !dm;
		end else begin
			page_locked = !lk[pg];
		end
	endfunction

	ffcl_ckind_t ck;
	logic [12:0] c_wd;
	logic c_inf;
	logic cache_on;
	logic [4:0] cmd_page;
	logic cmd_bad;
	logic wr_go;
	logic [1:0] wr_op;

	always_comb begin
		ck = cdecode(cread_extended_data_space, cread_addr);
		c_inf = ck == CK_INFO;
		c_wd = c_inf ? {4'h0, cread_addr[10:2]} : cread_addr[14:2];
		// disabled and real-time modes never hit, so every fetch costs the same
		cache_on = s_r.mode == CM_CACHED || s_r.mode == CM_PREFETCH;
		cmd_page = s_r.addr[PAGE_BITS +: 5];
		wr_go = s_r.aw_v && s_r.w_v && !s_r.bvalid;
		wr_op = s_r.w_d[1:0];
		case (wr_op)
			OP_WRITE: cmd_bad = s_r.addr[ADDR_INFO_BIT] || page_locked(s_r.lock, cmd_page, debug_mode);
			OP_PAGE_ERASE: cmd_bad = s_r.addr[ADDR_INFO_BIT] || page_locked(s_r.lock, cmd_page, debug_mode);
			OP_MASS_ERASE: cmd_bad = !debug_mode;
			default: cmd_bad = 1'b1;
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.pgm_start = 1'b0;
		s_nxt.i_rvalid = 1'b0;
		s_nxt.c_rvalid = 1'b0;

		// register bus
		if (s_axi_awvalid && !s_r.aw_v) begin
			s_nxt.aw_v = 1'b1;
			s_nxt.aw_a = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_r.w_v) begin
			s_nxt.w_v = 1'b1;
			s_nxt.w_d = s_axi_wdata;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (wr_go) begin
			s_nxt.aw_v = 1'b0;
			s_nxt.w_v = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = AXI_OKAY;
			unique case (s_r.aw_a)
				REG_CTRL: if (s_axi_wstrb[0]) s_nxt.mode = s_r.w_d[1:0];
				REG_STATUS: if (s_axi_wstrb[0] && s_r.w_d[ST_REFUSED_BIT]) s_nxt.refused = 1'b0;
				REG_LOCK: ;
				REG_ADDR: s_nxt.addr = s_r.w_d[16:0];
				REG_WDATA: s_nxt.wdata = s_r.w_d;
				REG_CMD: begin
					if (s_r.state == ST_BUSY || cmd_bad) begin
						s_nxt.refused = 1'b1;
					end else begin
						s_nxt.op = wr_op;
					end
				end
				default: s_nxt.bresp = AXI_SLVERR;
			endcase
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_r.rvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = AXI_OKAY;
			s_nxt.rdata = '0;
			unique case (s_axi_araddr)
				REG_CTRL: s_nxt.rdata[1:0] = s_r.mode;
				REG_STATUS: begin
					s_nxt.rdata[ST_BUSY_BIT] = s_r.state == ST_BUSY;
					s_nxt.rdata[ST_REFUSED_BIT] = s_r.refused;
					s_nxt.rdata[ST_IVALID_BIT] = s_r.i_v;
					s_nxt.rdata[ST_CVALID_BIT] = s_r.c_v;
					s_nxt.rdata[ST_PVALID_BIT] = s_r.p_v;
					s_nxt.rdata[ST_DBGLOCK_BIT] = s_r.lock[DBGLOCK_BIT];
					s_nxt.rdata[ST_DBGMODE_BIT] = debug_mode;
				end
				REG_LOCK: s_nxt.rdata = s_r.lock;
				REG_ADDR: s_nxt.rdata[16:0] = s_r.addr;
				REG_WDATA: s_nxt.rdata = s_r.wdata;
				REG_CMD: s_nxt.rdata[1:0] = s_r.op;
				default: s_nxt.rresp = AXI_SLVERR;
			endcase
		end

		// fetch path and programming
		unique case (s_r.state)
			ST_IDLE: begin
				if (s_r.op != OP_NONE) begin
					s_nxt.state = ST_BUSY;
					s_nxt.pgm_start = 1'b1;
					s_nxt.busy_cnt = s_r.op == OP_WRITE ? 20'(WRITE_CYC) : 20'(ERASE_CYCLES);
				end else if (cread_req && !s_r.c_rvalid) begin
					s_nxt.fill_lane = cread_addr[1:0];
					if (ck == CK_PORT0 || ck == CK_PORT1 || ck == CK_NONE) begin
						s_nxt.c_rvalid = 1'b1;
						s_nxt.c_rdata = ck == CK_PORT0 ? port0_in : ck == CK_PORT1 ? port1_in : 8'h00;
					end else if (cache_on && s_r.c_v && s_r.c_word == c_wd && s_r.c_info == c_inf) begin
						s_nxt.c_rvalid = 1'b1;
						s_nxt.c_rdata = byte_sel(s_r.c_data, cread_addr[1:0]);
					end else begin
						s_nxt.state = ST_FILL;
						s_nxt.fill_c = 1'b1;
						s_nxt.fill_info = c_inf;
						s_nxt.fill_word = c_wd;
						s_nxt.issued = 1'b0;
					end
				end else if (ifetch_req && !s_r.i_rvalid) begin
					s_nxt.fill_lane = ifetch_addr[1:0];
					if (cache_on && s_r.i_v && s_r.i_word == ifetch_addr[14:2]) begin
						s_nxt.i_rvalid = 1'b1;
						s_nxt.i_rdata = byte_sel(s_r.i_data, ifetch_addr[1:0]);
					end else if (s_r.mode == CM_PREFETCH && s_r.p_v && s_r.p_word == ifetch_addr[14:2]) begin
						s_nxt.i_v = 1'b1;
						s_nxt.i_word = s_r.p_word;
						s_nxt.i_data = s_r.p_data;
						s_nxt.p_v = 1'b0;
						s_nxt.i_rvalid = 1'b1;
						s_nxt.i_rdata = byte_sel(s_r.p_data, ifetch_addr[1:0]);
					end else begin
						s_nxt.state = ST_FILL;
						s_nxt.fill_c = 1'b0;
						s_nxt.fill_info = 1'b0;
						s_nxt.fill_word = ifetch_addr[14:2];
						s_nxt.issued = 1'b0;
					end
				end
			end
			ST_FILL: begin
				s_nxt.issued = 1'b1;
				if (s_r.issued && fl_rd_valid) begin
					s_nxt.state = ST_IDLE;
					if (s_r.fill_c) begin
						s_nxt.c_v = 1'b1;
						s_nxt.c_info = s_r.fill_info;
						s_nxt.c_word = s_r.fill_word;
						s_nxt.c_data = fl_rd_data;
						s_nxt.c_rvalid = 1'b1;
						s_nxt.c_rdata = byte_sel(fl_rd_data, s_r.fill_lane);
					end else begin
						s_nxt.i_v = 1'b1;
						s_nxt.i_word = s_r.fill_word;
						s_nxt.i_data = fl_rd_data;
						s_nxt.i_rvalid = 1'b1;
						s_nxt.i_rdata = byte_sel(fl_rd_data, s_r.fill_lane);
						// run ahead one word only in prefetch mode; costs wasted reads
						if (s_r.mode == CM_PREFETCH && s_r.fill_word != DBG_WORD) begin
							s_nxt.state = ST_PREF;
							s_nxt.fill_word = s_r.fill_word + 13'h1;
							s_nxt.issued = 1'b0;
						end
					end
				end
			end
			ST_PREF: begin
				s_nxt.issued = 1'b1;
				if (s_r.issued && fl_rd_valid) begin
					s_nxt.state = ST_IDLE;
					s_nxt.p_v = 1'b1;
					s_nxt.p_word = s_r.fill_word;
					s_nxt.p_data = fl_rd_data;
				end
			end
			ST_BUSY: begin
				s_nxt.busy_cnt = s_r.busy_cnt - 20'h1;
				if (s_r.busy_cnt == 20'h1) begin
					s_nxt.state = ST_IDLE;
					s_nxt.op = OP_NONE;
					s_nxt.i_v = 1'b0;
					s_nxt.c_v = 1'b0;
					s_nxt.p_v = 1'b0;
					// flash bits only clear on write; erase of the top page sets them
					if (s_r.op == OP_MASS_ERASE || (s_r.op == OP_PAGE_ERASE && cmd_page == TOP_PAGE)) begin
						s_nxt.lock = LOCK_RESET;
					end else if (s_r.op == OP_WRITE && s_r.addr[14:2] == LOCK_WORD) begin
						s_nxt.lock[DBGLOCK_BIT - 1:0] = s_r.lock[DBGLOCK_BIT - 1:0] & s_r.wdata[DBGLOCK_BIT - 1:0];
					end else if (s_r.op == OP_WRITE && s_r.addr[14:2] == DBG_WORD) begin
						s_nxt.lock[DBGLOCK_BIT] = s_r.lock[DBGLOCK_BIT] & s_r.wdata[DBGLOCK_BIT];
					end
				end
			end
		endcase
	end

	// state holds while ce is low, so sleep loses nothing and needs no restore
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= REGS_RESET;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_awready = !s_r.aw_v;
	assign s_axi_wready = !s_r.w_v;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign ifetch_rvalid = s_r.i_rvalid;
	assign ifetch_rdata = s_r.i_rdata;
	assign cread_rvalid = s_r.c_rvalid;
	assign cread_rdata = s_r.c_rdata;
	assign fl_rd_req = (s_r.state == ST_FILL || s_r.state == ST_PREF) && !s_r.issued;
	assign fl_rd_info = s_r.fill_info;
	assign fl_rd_word = s_r.fill_word;
	assign fl_pgm_start = s_r.pgm_start;
	assign fl_pgm_op = s_r.op;
	assign fl_pgm_addr = s_r.addr;
	assign fl_pgm_wdata = s_r.wdata;
	assign dbg_cmd_accept = dbg_cmd_valid && (s_r.lock[DBGLOCK_BIT] || dbg_cmd_safe);
endmodule
`default_nettype wire

// ==== rtl/ffcl_pkg.sv ====
package ffcl_pkg;
	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LOCK = 8'h08;
	localparam logic [7:0] REG_ADDR = 8'h0C;
	localparam logic [7:0] REG_WDATA = 8'h10;
	localparam logic [7:0] REG_CMD = 8'h14;
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_REFUSED_BIT = 1;
	localparam int ST_IVALID_BIT = 2;
	localparam int ST_CVALID_BIT = 3;
	localparam int ST_PVALID_BIT = 4;
	localparam int ST_DBGLOCK_BIT = 5;
	localparam int ST_DBGMODE_BIT = 6;
	localparam int ADDR_INFO_BIT = 16;
	localparam int DBGLOCK_BIT = 31;
	localparam logic [1:0] CM_OFF = 2'h0;
	localparam logic [1:0] CM_CACHED = 2'h1;
	localparam logic [1:0] CM_PREFETCH = 2'h2;
	localparam logic [1:0] CM_REALTIME = 2'h3;
	localparam logic [1:0] CM_RESET = CM_CACHED;
	localparam logic [1:0] OP_NONE = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_PAGE_ERASE = 2'h2;
	localparam logic [1:0] OP_MASS_ERASE = 2'h3;
	localparam logic [31:0] LOCK_RESET = 32'hFFFF_FFFF;
	// ----------------------------------------
	// flash geometry
	// ----------------------------------------
	localparam int PAGE_BITS = 10;
	localparam int NUM_PAGES = 32;
	localparam int WORD_BITS = 13;
	localparam logic [4:0] TOP_PAGE = 5'h1F;
	localparam logic [12:0] LOCK_WORD = 13'h1FFC;
	localparam logic [12:0] DBG_WORD = 13'h1FFF;
	localparam logic [15:0] PORT0_XADDR = 16'h7080;
	localparam logic [15:0] PORT1_XADDR = 16'h7090;
	localparam logic [15:0] INFO_XBASE = 16'h7800;
	localparam logic [15:0] XBANK_BASE = 16'h8000;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_KHZ = 20000;
	localparam int ERASE_TIME_MS = 20;
	localparam int WRITE_TIME_US = 20;
	localparam int ERASE_CYC = ERASE_TIME_MS * CLK_KHZ;
	localparam int WRITE_CYC = (WRITE_TIME_US * CLK_KHZ + 999) / 1000;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_FILL = 2'h1,
		ST_PREF = 2'h3,
		ST_BUSY = 2'h2
	} ffcl_state_t;
	typedef enum logic [2:0] {
		CK_NONE, CK_FLASH, CK_INFO, CK_PORT0, CK_PORT1
	} ffcl_ckind_t;
endpackage

// ==== tb/ffcl_top_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module ffcl_chk import ffcl_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic ifetch_rvalid,
	input wire logic fl_rd_req,
	input wire logic fl_rd_info,
	input wire logic [12:0] fl_rd_word,
	input wire logic fl_pgm_start,
	input wire logic [1:0] fl_pgm_op,
	input wire logic [16:0] fl_pgm_addr,
	input wire logic debug_mode,
	input wire logic dbg_cmd_valid,
	input wire logic dbg_cmd_safe,
	input wire logic dbg_cmd_accept
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	dbg_gate_a: assert property (dbg_cmd_accept |-> dbg_cmd_valid)
		else $error("debug accept without command");
	dbg_safe_a: assert property (dbg_cmd_valid && dbg_cmd_safe |-> dbg_cmd_accept)
		else $error("safe debug command dropped");
	info_ro_a: assert property (fl_pgm_start |-> !fl_pgm_addr[ADDR_INFO_BIT])
		else $error("info region programmed");
	top_page_a: assert property (fl_pgm_start && (fl_pgm_op == OP_MASS_ERASE || fl_pgm_addr[14:10] == TOP_PAGE) |-> debug_mode)
		else $error("lock page touched outside debug");
	pgm_once_a: assert property (fl_pgm_start |=> !fl_pgm_start [*8])
		else $error("program restarted while busy");
	rd_word_a: assert property (fl_rd_req |=> $stable({fl_rd_info, fl_rd_word}))
		else $error("flash word moved");
	fetch_pulse_a: assert property (ifetch_rvalid |=> !ifetch_rvalid)
		else $error("fetch answer stretched");
	cover property (fl_pgm_start && fl_pgm_op == OP_MASS_ERASE);
	cover property (dbg_cmd_valid && !dbg_cmd_accept);
	cover property (ifetch_rvalid);
endmodule
bind ffcl_top ffcl_chk u_ffcl_chk (.*);
`default_nettype wire

// ==== tb/ffcl_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ffcl_flash_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic fl_rd_req,
	input wire logic fl_rd_info,
	input wire logic [12:0] fl_rd_word,
	input wire logic fl_slow,
	output logic fl_rd_valid,
	output logic [31:0] fl_rd_data
);
	logic [2:0] cnt_r;
	// data toggles outside valid so a stale word never passes as an answer
	always_ff @(posedge aclk) begin
		fl_rd_valid <= 1'b0;
		fl_rd_data <= ~fl_rd_data;
		if (!aresetn) begin
			cnt_r <= 3'h0;
			fl_rd_data <= 32'h0;
		end else if (fl_rd_req) begin
			cnt_r <= fl_slow ? 3'h4 : 3'h1;
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
			if (cnt_r == 3'h1) begin
				fl_rd_valid <= 1'b1;
				fl_rd_data <= {fl_rd_info, 2'h0, fl_rd_word, 3'h5, fl_rd_word};
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb import ffcl_pkg::*;;
	typedef struct {int k; logic [15:0] a; logic [7:0] d; int n;} ffcl_row_t;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ifetch_req, ifetch_rvalid, cread_req;
	logic cread_extended_data_space, cread_rvalid, fl_rd_req, fl_rd_info, fl_rd_valid, fl_pgm_start, debug_mode;
	logic dbg_cmd_valid, dbg_cmd_safe, dbg_cmd_accept, fl_slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr, ifetch_rdata, cread_rdata, port0_in, port1_in;
	logic [31:0] s_axi_wdata, s_axi_rdata, fl_rd_data, fl_pgm_wdata, rdv, pwd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, fl_pgm_op, rsp, pop;
	logic [14:0] ifetch_addr;
	logic [15:0] cread_addr;
	logic [12:0] fl_rd_word;
	logic [16:0] fl_pgm_addr, pad;
	int bad_count, total_checks, nrd, nst, cyc, t_st;
	ffcl_row_t rows[8];
	logic [16:0] rf_a[6];
	logic [1:0] rf_o[6];
	ffcl_top #(.ERASE_CYCLES(20)) u_ffcl_top (.*);
	ffcl_flash_model u_ffcl_flash_model (.*);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) cyc++;
	always @(negedge aclk) begin
		if (fl_rd_req === 1'b1) nrd++;
		if (fl_pgm_start === 1'b1) begin
			nst++;
			t_st = cyc;
			pop = fl_pgm_op;
			pad = fl_pgm_addr;
			pwd = fl_pgm_wdata;
		end
	end
	function automatic logic [7:0] fb(input logic i, input logic [12:0] w, input int b);
		logic [31:0] x;
		x = {i, 2'h0, w, 3'h5, w};
		return x[8*b +: 8];
	endfunction
	task automatic stop_test;
		if (bad_count == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic tmo;
		chk(1'b0, "timeout");
		stop_test;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, kb;
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		repeat (100) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			kb = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (kb) begin
				s_axi_bready <= 1'b0;
				return;
			end
		end
		tmo;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, kr;
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		s_axi_araddr <= a;
		repeat (100) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			kr = s_axi_rvalid;
			rdv = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (kr) begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		tmo;
	endtask
	task automatic fe(input int k, input logic [15:0] a, output int lat);
		@(posedge aclk);
		if (k == 2) begin
			ifetch_req <= 1'b1;
			ifetch_addr <= a[14:0];
		end else begin
			cread_req <= 1'b1;
			cread_extended_data_space <= k[0];
			cread_addr <= a;
		end
		for (lat = 1; lat < 100; lat++) begin
			@(negedge aclk);
			if ((k == 2 ? ifetch_rvalid : cread_rvalid) === 1'b1) begin
				rdv = {24'h0, k == 2 ? ifetch_rdata : cread_rdata};
				@(posedge aclk);
				ifetch_req <= 1'b0;
				cread_req <= 1'b0;
				return;
			end
		end
		tmo;
	endtask
	task automatic cmd(input logic [16:0] a, input logic [1:0] op, input logic [31:0] d);
		wr(REG_ADDR, {15'h0, a});
		wr(REG_WDATA, d);
		wr(REG_CMD, {30'h0, op});
	endtask
	task automatic idle(input int n0, input int cycles);
		for (int n = 0; n < 20 && nst == n0; n++) @(posedge aclk);
		chk(nst == n0 + 1, "no program start");
		repeat (1000) begin
			rd(REG_STATUS);
			if (rdv[ST_BUSY_BIT] === 1'b0) begin
				chk(cyc - t_st >= cycles - 1 && cyc - t_st <= cycles + 12, "busy time");
				return;
			end
		end
		tmo;
	endtask
	initial begin
		int n0, l1, l2, hl;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{ifetch_req, cread_req, cread_extended_data_space, debug_mode, dbg_cmd_valid, dbg_cmd_safe} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, ifetch_addr, cread_addr} = '0;
		{bad_count, total_checks, nrd, nst, cyc, t_st} = '0;
		ce = 1'b1;
		fl_slow = 1'b1;
		s_axi_wstrb = 4'hF;
		port0_in = 8'hA5;
		port1_in = 8'h3C;
		rows = '{'{2, 16'h00F1, fb(0, 13'h3C, 1), 1}, '{2, 16'h00F3, fb(0, 13'h3C, 3), 0},
			'{0, 16'h00F2, fb(0, 13'h3C, 2), 1}, '{1, 16'h7080, 8'hA5, 0}, '{1, 16'h7090, 8'h3C, 0},
			'{1, 16'h7805, fb(1, 13'h1, 1), 1}, '{1, 16'h1234, 8'h00, 0}, '{0, 16'h8000, 8'h00, 0}};
		rf_a = '{17'h00400, 17'h00400, 17'h07C00, 17'h00000, 17'h10000, 17'h00000};
		rf_o = '{OP_WRITE, OP_PAGE_ERASE, OP_PAGE_ERASE, OP_MASS_ERASE, OP_WRITE, OP_NONE};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			n0 = nrd;
			fe(rows[i].k, rows[i].a, l1);
			chk(rdv[7:0] === rows[i].d && nrd - n0 == rows[i].n, "fetch byte");
		end
		fl_slow <= 1'b0;
		rd(REG_CTRL);
		chk(rdv[1:0] === CM_RESET && rsp === AXI_OKAY, "mode after reset");
		rd(REG_LOCK);
		chk(rdv === LOCK_RESET, "lock image");
		wr(8'h18, 32'h0);
		chk(rsp === AXI_SLVERR, "unmapped write");
		for (int m = 0; m < 4; m++) begin
			wr(REG_CTRL, m);
			n0 = nrd;
			fe(2, 16'h0200 + 16'(m * 16), l1);
			fe(2, 16'h0200 + 16'(m * 16), l2);
			repeat (10) @(posedge aclk);
			chk(nrd - n0 == (m == 1 ? 1 : 2), "flash reads per mode");
			if (m == 1) hl = l2;
			if (m == 1) chk(l2 < l1, "hit not faster");
			if (m == 3) chk(l1 == l2, "real-time timing varies");
		end
		wr(REG_CTRL, CM_PREFETCH);
		fe(2, 16'h0300, l1);
		repeat (10) @(posedge aclk);
		fe(2, 16'h0304, l2);
		chk(l2 == hl && rdv[7:0] === fb(0, 13'hC1, 0), "prefetch hit");
		wr(REG_CTRL, CM_CACHED);
		fe(2, 16'h0100, l1);
		fe(0, 16'h0100, l1);
		n0 = nst;
		cmd(17'h00100, OP_WRITE, 32'h1234_5678);
		idle(n0, WRITE_CYC);
		chk(pop === OP_WRITE && pad === 17'h00100 && pwd === 32'h1234_5678, "write command");
		rd(REG_STATUS);
		chk(rdv[ST_IVALID_BIT] === 1'b0 && rdv[ST_CVALID_BIT] === 1'b0, "stale cache");
		debug_mode <= 1'b1;
		n0 = nst;
		cmd(17'h07FF0, OP_WRITE, 32'hFFFF_FFFD);
		idle(n0, WRITE_CYC);
		rd(REG_LOCK);
		chk(rdv === 32'hFFFF_FFFD, "lock bits");
		debug_mode <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			wr(REG_STATUS, 32'h2);
			n0 = nst;
			cmd(rf_a[i], rf_o[i], 32'h0);
			rd(REG_STATUS);
			chk(rdv[ST_REFUSED_BIT] === 1'b1 && nst == n0, "command not refused");
		end
		debug_mode <= 1'b1;
		dbg_cmd_valid <= 1'b1;
		@(negedge aclk);
		chk(dbg_cmd_accept === 1'b1, "unlocked debug");
		n0 = nst;
		cmd(17'h07FFC, OP_WRITE, 32'h7FFF_FFFF);
		idle(n0, WRITE_CYC);
		@(negedge aclk);
		chk(dbg_cmd_accept === 1'b0, "locked debug");
		@(posedge aclk);
		dbg_cmd_safe <= 1'b1;
		@(negedge aclk);
		chk(dbg_cmd_accept === 1'b1, "safe debug command");
		@(posedge aclk);
		dbg_cmd_safe <= 1'b0;
		n0 = nst;
		cmd(17'h00000, OP_MASS_ERASE, 32'h0);
		idle(n0, 20);
		rd(REG_LOCK);
		chk(rdv === LOCK_RESET, "erase lock restore");
		wr(REG_CTRL, CM_PREFETCH);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(REG_CTRL);
		chk(rdv[1:0] === CM_RESET, "mode after second reset");
		stop_test;
	end
	initial begin
		repeat (90000) @(posedge aclk);
		tmo;
	end
endmodule
`default_nettype wire
